// >>> src/wdc_consts.vh
// Constants of the watchdog mode and time-out controller
`ifndef WDC_CONSTS_VH
`define WDC_CONSTS_VH
// Byte addresses of the registers
`define WDC_ADDR_CSR 4'h0
`define WDC_ADDR_CAUSE 4'h4
`define WDC_ADDR_LSB 2
`define WDC_ADDR_MSB 3
// Control/status register fields
`define WDC_BIT_FLAG 7
`define WDC_BIT_IRQ_EN 6
`define WDC_BIT_SEL_HI 5
`define WDC_BIT_UNLOCK 4
`define WDC_BIT_RST_EN 3
`define WDC_SEL_LO_MSB 2
`define WDC_SEL_LO_LSB 0
// Reset cause register fields
`define WDC_BIT_WATCHDOG_RESET_FLAG 0
`define WDC_MODE_LSB 1
`define WDC_MODE_MSB 2
// Modes of operation
`define WDC_MODE_STOP 2'h0
`define WDC_MODE_IRQ 2'h1
`define WDC_MODE_RST 2'h2
`define WDC_MODE_BOTH 2'h3
// Unlock window length minus one, in bus clock cycles
`define WDC_UNLOCK_LAST 3'h3
// Time-out select encoding
`define WDC_SEL_LAST_UP 4'h9
`define WDC_SEL_LAST_DOWN 4'hD
`define WDC_LOG2_BASE 5'h0B
`define WDC_LOG2_DOWN_REF 5'h14
`define WDC_CNT_W 21
`define WDC_CNT_ONE 21'h000001
`define WDC_CNT_ZERO 21'h000000
// Oscillator and fuse levels
`define WDC_OSC_HZ 128000
`define WDC_FUSE_PROGRAMMED 1'b0
`define WDC_FUSE_RESET 1'b0
`define WDC_HTRANS_ACTIVE 1
`endif

// >>> src/wdc_watchdog.v
// Watchdog mode and time-out controller with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "wdc_consts.vh"
module wdc_watchdog
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire osc_clk,
  input wire always_on_fuse,
  input wire global_irq_enable,
  input wire vector_taken,
  input wire restart_instr,
  output reg wdt_irq,
  output reg system_reset_req
);

  // Time-out length in oscillator cycles for a select code
  // The counter is wide enough for the longest limit of 2^20 cycles
  function [`WDC_CNT_W-1:0] wdc_limit;
    input [3:0] sel;
    begin
      if (sel <= `WDC_SEL_LAST_UP)
        wdc_limit = `WDC_CNT_ONE << (`WDC_LOG2_BASE + {1'b0, sel});
      else if (sel <= `WDC_SEL_LAST_DOWN)
        wdc_limit = `WDC_CNT_ONE << (`WDC_LOG2_DOWN_REF - {1'b0, sel});
      else
        wdc_limit = `WDC_CNT_ONE << `WDC_LOG2_BASE; // Reserved codes
    end
  endfunction

  // Matches an aligned in-range address against one register
  function wdc_hit;
    input [31:0] addr;
    input [3:0] reg_addr;
    begin
      wdc_hit = (addr[31:`WDC_ADDR_MSB+1] == 28'h0000000)
        && (addr[`WDC_ADDR_MSB:0] == reg_addr);
    end
  endfunction

  reg osc_meta;
  reg osc_sync;
  reg osc_prev;
  reg fuse_meta;
  reg fuse_sync;
  reg wr_pend;
  reg [3:0] wr_addr;
  reg flag;
  reg irq_en;
  reg rst_en;
  reg unlock;
  reg [2:0] unlock_cnt;
  reg [3:0] sel;
  reg watchdog_reset_flag;
  reg [`WDC_CNT_W-1:0] count;
  reg next_flag;
  reg next_irq_en;
  reg next_rst_en;
  reg next_unlock;
  reg [2:0] next_unlock_cnt;
  reg [3:0] next_sel;
  reg [31:0] rd_value;
  wire fuse_prog;
  wire rst_en_eff;
  wire irq_en_eff;
  wire [1:0] mode;
  wire osc_tick;
  wire timeout;
  wire running;
  wire addr_ok;
  wire wr_csr;
  wire wr_cause;
  wire [7:0] wbyte;
  wire fire_reset;

  // Oscillator and fuse pass two flops; edge detect reads the second
  // The fuse flops reset to programmed, so the block starts in the
  // safe reset mode until the real fuse level has been sampled
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      fuse_meta <= `WDC_FUSE_RESET;
      fuse_sync <= `WDC_FUSE_RESET;
    end
    else
    begin
      osc_meta <= osc_clk;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      fuse_meta <= always_on_fuse;
      fuse_sync <= fuse_meta;
    end
  end

  assign osc_tick = osc_sync & ~osc_prev;
  assign fuse_prog = (fuse_sync == `WDC_FUSE_PROGRAMMED);

  // Effective enables after fuse and reset-flag overrides
  // The reset flag holds the reset enable set, so a system that keeps
  // failing keeps being reset until software has cleared the cause
  // The fuse wins over both bits and over any write
  assign rst_en_eff = rst_en | watchdog_reset_flag | fuse_prog;
  assign irq_en_eff = irq_en & ~fuse_prog;
  assign mode = fuse_prog ? `WDC_MODE_RST : {rst_en_eff, irq_en_eff};
  assign running = (mode != `WDC_MODE_STOP);

  // Time-out on the oscillator edge that completes the selected count
  // A count already past a newly shortened limit times out at the next
  // tick instead of running round the whole counter first
  // Ticks arrive a few bus cycles after the pin edge, through the flops
  assign timeout = running & osc_tick
    & (count >= wdc_limit(sel) - `WDC_CNT_ONE);

  // Reset in reset mode, or in combined mode when flag still pending
  // A flag still pending means the last interrupt was never serviced
  assign fire_reset = timeout & ((mode == `WDC_MODE_RST)
    | ((mode == `WDC_MODE_BOTH) & flag));

  // Time-out counter
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= `WDC_CNT_ZERO;
    else if (restart_instr | ~running | timeout)
      count <= `WDC_CNT_ZERO;
    else if (osc_tick)
      count <= count + `WDC_CNT_ONE;
  end

  // AHB-Lite address phase capture
  // Zero wait states: a write lands at the end of its data phase, while
  // read data are taken at the address phase, so a read right behind a
  // write to the same register returns the old value
  // Unmapped addresses answer OKAY, read zero and ignore writes
  assign addr_ok = (haddr[31:`WDC_ADDR_MSB+1] == 28'h0000000)
    & (haddr[`WDC_ADDR_LSB-1:0] == 2'h0);
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= `WDC_ADDR_CSR;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel & htrans[`WDC_HTRANS_ACTIVE] & hready & hwrite
        & addr_ok;
      wr_addr <= haddr[`WDC_ADDR_MSB:0];
    end
  end

  assign wbyte = hwdata[7:0];
  assign wr_csr = wr_pend & (wr_addr == `WDC_ADDR_CSR);
  assign wr_cause = wr_pend & (wr_addr == `WDC_ADDR_CAUSE);

  // Control/status next values
  // Later assignments in this process take priority over earlier ones
  always @*
  begin
    next_flag = flag;
    next_irq_en = irq_en;
    next_rst_en = rst_en;
    next_unlock = unlock;
    next_unlock_cnt = unlock_cnt;
    next_sel = sel;
    // Unlock window count-down
    // The window is counted in bus cycles from the unlocking write; a
    // later write with the unlock bit clear does not shorten it, so the
    // bit still reads one until the window has run out
    if (unlock)
    begin
      if (unlock_cnt == 3'h0)
        next_unlock = 1'b0;
      else
        next_unlock_cnt = unlock_cnt - 3'h1;
    end
    // Vector taken clears flag and, in combined mode, irq enable
    // In interrupt-only mode the enable survives, so interrupts go on
    // being given at every time-out
    if (vector_taken)
    begin
      next_flag = 1'b0;
      if (rst_en_eff)
        next_irq_en = 1'b0;
    end
    if (wr_csr)
    begin
      if (wbyte[`WDC_BIT_FLAG])
        next_flag = 1'b0;
      // A write of the irq enable wins over the vector's clear
      if (wbyte[`WDC_BIT_IRQ_EN])
        next_irq_en = 1'b1;
      else if (!vector_taken)
        next_irq_en = 1'b0;
      if (wbyte[`WDC_BIT_UNLOCK] & wbyte[`WDC_BIT_RST_EN])
      begin
        next_unlock = 1'b1;
        next_unlock_cnt = `WDC_UNLOCK_LAST;
        next_rst_en = 1'b1;
      end
      else if (unlock)
      begin
        next_rst_en = wbyte[`WDC_BIT_RST_EN];
        // Select bits sit on either side of the unlock bit in the byte
        next_sel = {wbyte[`WDC_BIT_SEL_HI],
          wbyte[`WDC_SEL_LO_MSB:`WDC_SEL_LO_LSB]};
      end
      else
        next_rst_en = rst_en | wbyte[`WDC_BIT_RST_EN];
    end
    // Time-out sets the flag in irq or combined mode; set wins over clear
    if (timeout & irq_en_eff & ~fire_reset)
      next_flag = 1'b1;
    if (fuse_prog)
      next_irq_en = 1'b0;
  end

  // Control/status register
  // All control state moves together on one edge
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flag <= 1'b0;
      irq_en <= 1'b0;
      rst_en <= 1'b0;
      unlock <= 1'b0;
      unlock_cnt <= 3'h0;
      sel <= 4'h0;
    end
    else
    begin
      flag <= next_flag;
      irq_en <= next_irq_en;
      rst_en <= next_rst_en;
      unlock <= next_unlock;
      unlock_cnt <= next_unlock_cnt;
      sel <= next_sel;
    end
  end

  // Watchdog reset flag: set by a watchdog reset, cleared by writing zero
  // A new watchdog reset wins over a clearing write in the same cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      watchdog_reset_flag <= 1'b0;
    else if (fire_reset)
      watchdog_reset_flag <= 1'b1;
    else if (wr_cause & ~hwdata[`WDC_BIT_WATCHDOG_RESET_FLAG])
      watchdog_reset_flag <= 1'b0;
  end

  // Interrupt and system reset request outputs
  // The interrupt follows the next flag and enable values, so it rises
  // at the same edge as the flag
  // The reset request stays high until the block itself is reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wdt_irq <= 1'b0;
      system_reset_req <= 1'b0;
    end
    else
    begin
      wdt_irq <= next_flag & next_irq_en & global_irq_enable;
      if (fire_reset)
        system_reset_req <= 1'b1;
    end
  end

  // Read multiplexer; reserved and upper bits read as zero
  always @*
  begin
    rd_value = 32'h00000000;
    if (wdc_hit(haddr, `WDC_ADDR_CSR))
    begin
      rd_value[`WDC_BIT_FLAG] = flag;
      rd_value[`WDC_BIT_IRQ_EN] = irq_en_eff;
      rd_value[`WDC_BIT_SEL_HI] = sel[3];
      rd_value[`WDC_BIT_UNLOCK] = unlock;
      rd_value[`WDC_BIT_RST_EN] = rst_en_eff;
      rd_value[`WDC_SEL_LO_MSB:`WDC_SEL_LO_LSB] = sel[2:0];
    end
    else if (wdc_hit(haddr, `WDC_ADDR_CAUSE))
    begin
      rd_value[`WDC_BIT_WATCHDOG_RESET_FLAG] = watchdog_reset_flag;
      rd_value[`WDC_MODE_MSB:`WDC_MODE_LSB] = mode;
    end
  end

  // Read data registered at the address phase for the data phase
  // hrdata then holds until the next read address is taken
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (hsel & htrans[`WDC_HTRANS_ACTIVE] & hready & ~hwrite)
      hrdata <= rd_value;
  end

endmodule // wdc_watchdog
`default_nettype wire

// >>> test/wdc_watchdog_bench.sv
// Self-checking bench of the watchdog controller
`timescale 1ns/10ps
`default_nettype none
module wdc_watchdog_bench;
  logic hclk = 0, hresetn = 0, hwrite = 0, osc_clk = 0, rdp = 0;
  logic always_on_fuse = 1, global_irq_enable = 1, vector_taken = 0;
  logic restart_instr = 0, hreadyout, hresp, wdt_irq, system_reset_req;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, expq[$];
  logic [1:0] htrans = 0;
  logic [7:0] lfsr = 8'h56, v;
  int bad_count = 0, comparisons = 0, cyc = 0, n, i;
  // Bus clock and a slower oscillator of unrelated period
  always #25 hclk = ~hclk;
  always #101 osc_clk = ~osc_clk;
  wdc_watchdog uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_clk(osc_clk),
    .always_on_fuse(always_on_fuse), .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken), .restart_instr(restart_instr),
    .wdt_irq(wdt_irq), .system_reset_req(system_reset_req));
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Single transfer; a read notes its expected data first
  task automatic xfer(input logic w, input logic [7:0] a, d, e);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    if (!w)
      expq.push_back({24'h0, e});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic pulse(input logic k);
    restart_instr <= k;
    vector_taken <= !k;
    @(posedge hclk);
    restart_instr <= 0;
    vector_taken <= 0;
    @(posedge hclk);
  endtask
  // Cycles until irq (k=0) or reset request (k=1), within a window
  task automatic waitfor(input logic k, input int lo, input int hi);
    n = 0;
    while ((k ? system_reset_req : wdt_irq) !== 1'b1 && n < 2000)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  // Read data compared in the data phase after the read address
  always @(posedge hclk)
  begin
    if (rdp && hreadyout)
    begin
      chk(hrdata, expq.pop_front());
      chk(32'(hresp), 32'h0);
    end
    if (hreadyout)
      rdp <= htrans[1] && !hwrite;
  end
  // Hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    repeat (4) @(posedge hclk);
    xfer(1, 8'h0, 8'h58, 8'h0);
    repeat (3) @(posedge hclk);
    xfer(0, 8'h0, 8'h0, 8'h58);
    xfer(0, 8'h0, 8'h0, 8'h48);
    // Load every select code, ending on 128 cycles
    // Unlock still reads one in the read that follows each change
    for (i = 0; i < 16; i++)
    begin
      n = (i + 14) % 16;
      v = {2'h1, n[3], 2'h0, n[2:0]};
      xfer(1, 8'h0, 8'h58, 8'h0);
      xfer(1, 8'h0, v, 8'h0);
      xfer(0, 8'h0, 8'h0, v | 8'h10);
    end
    xfer(1, 8'h0, 8'h40, 8'h0);
    xfer(0, 8'h0, 8'h0, 8'h65);
    xfer(0, 8'h4, 8'h0, 8'h02);
    lfsr = nx(lfsr);
    repeat (lfsr[2:0]) @(posedge hclk);
    pulse(1);
    waitfor(0, 505, 530);
    global_irq_enable <= 0;
    repeat (2) @(posedge hclk);
    chk(32'({wdt_irq, system_reset_req}), 32'h0);
    global_irq_enable <= 1;
    repeat (2) @(posedge hclk);
    chk(32'(wdt_irq), 32'h1);
    xfer(1, 8'h0, 8'hE5, 8'h0);
    xfer(0, 8'h0, 8'h0, 8'h65);
    // Combined mode: interrupt first, reset when left unserviced
    xfer(1, 8'h0, 8'h58, 8'h0);
    xfer(1, 8'h0, 8'h6D, 8'h0);
    pulse(1);
    waitfor(0, 505, 530);
    chk(32'(system_reset_req), 32'h0);
    pulse(0);
    xfer(0, 8'h0, 8'h0, 8'h2D);
    xfer(1, 8'h0, 8'h6D, 8'h0);
    waitfor(0, 0, 530);
    waitfor(1, 505, 530);
    xfer(0, 8'h4, 8'h0, 8'h07);
    xfer(1, 8'h0, 8'h58, 8'h0);
    xfer(1, 8'h0, 8'h45, 8'h0);
    xfer(0, 8'h0, 8'h0, 8'hDD);
    xfer(1, 8'h4, 8'h0, 8'h0);
    xfer(1, 8'h0, 8'h58, 8'h0);
    xfer(1, 8'h0, 8'hC5, 8'h0);
    xfer(0, 8'h0, 8'h0, 8'h55);
    // Programmed fuse forces reset mode
    always_on_fuse <= 0;
    repeat (4) @(posedge hclk);
    xfer(0, 8'h0, 8'h0, 8'h0D);
    xfer(0, 8'h4, 8'h0, 8'h04);
    lfsr = nx(lfsr);
    xfer(1, {lfsr[7:3], 3'h0} | 8'h08, lfsr, 8'h0);
    xfer(0, {lfsr[7:3], 3'h0} | 8'h08, 8'h0, 8'h0);
    xfer(0, 8'h0, 8'h0, 8'h0D);
    repeat (2) @(posedge hclk);
    close_out();
  end
endmodule // wdc_watchdog_bench
`default_nettype wire

// >>> test/wdc_watchdog_monitor.sv
// Port checker of the watchdog controller
`timescale 1ns/10ps
`default_nettype none
module wdc_monitor
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic always_on_fuse,
  input wire logic global_irq_enable,
  input wire logic vector_taken,
  input wire logic wdt_irq,
  input wire logic system_reset_req
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read address phase taken by the slave
  wire logic rd = hsel && htrans[1] && hready && !hwrite;
  property p_gie; !global_irq_enable |=> !wdt_irq; endproperty
  a_gie: assert property (p_gie) else $error("irq while off");
  property p_vec; vector_taken && wdt_irq |=> !wdt_irq; endproperty
  a_vec: assert property (p_vec) else $error("vector kept irq");
  property p_hold; system_reset_req |=> system_reset_req; endproperty
  a_hold: assert property (p_hold) else $error("reset dropped");
  property p_fuse; !always_on_fuse [*5] |-> !wdt_irq; endproperty
  a_fuse: assert property (p_fuse) else $error("irq with fuse");
  property p_lock;
    !always_on_fuse [*5] ##0 (rd && haddr == 32'h0)
      |=> hrdata[3] && !hrdata[6];
  endproperty
  a_lock: assert property (p_lock) else $error("enables free");
  property p_map;
    rd && haddr != 32'h0 && haddr != 32'h4 |=> hrdata == 32'h0;
  endproperty
  a_map: assert property (p_map) else $error("unmapped data");
  property p_top; rd |=> hrdata[31:8] == 24'h0; endproperty
  a_top: assert property (p_top) else $error("upper bits set");
  property p_keep; !rd |=> $stable(hrdata); endproperty
  a_keep: assert property (p_keep) else $error("data moved");
  c_irq: cover property ($rose(wdt_irq));
  c_rst: cover property ($rose(system_reset_req));
  c_vec: cover property (vector_taken && wdt_irq);
endmodule // wdc_monitor
bind wdc_watchdog wdc_monitor chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .always_on_fuse(always_on_fuse),
  .global_irq_enable(global_irq_enable), .vector_taken(vector_taken),
  .wdt_irq(wdt_irq), .system_reset_req(system_reset_req));
`default_nettype wire
